// ### hw/ppcf_top.sv
// pad configuration registers and input filters for two pins
`timescale 1ns/1ns
`include "ppcf_map.svh"

module ppcf_top #(
    parameter int NUM_PINS = 2
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    input wire logic [6:0] div_tick_i,
    input wire logic [NUM_PINS-1:0] pin_i,
    input wire logic [NUM_PINS-1:0] gpio_out_i,
    input wire logic [NUM_PINS-1:0] gpio_dir_i,
    output logic [NUM_PINS-1:0] pin_level_o,
    output logic [NUM_PINS-1:0] pad_drive_o,
    output logic [NUM_PINS-1:0] pad_oe_o,
    output logic [2*NUM_PINS-1:0] pull_mode_o,
    output logic [NUM_PINS-1:0] schmitt_trigger_select_o
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------

    // address to register index; bit 1 of the result marks a hit
    function automatic logic [1:0] addr_dec(input logic [31:0] a);
        logic [1:0] r;
        r = 2'h0;
        if (a == `PPCF_PIN_TWELVE_ADDR) begin
            r = 2'h2;
        end else if (a == `PPCF_PIN_FIVE_ADDR) begin
            r = 2'h3;
        end
        return r;
    endfunction : addr_dec

    // value software sees: writable bits plus fixed reserved ones
    function automatic logic [31:0] cfg_view(input logic [31:0] c);
        return (c & `PPCF_CFG_WMASK) | `PPCF_CFG_FIXED;
    endfunction : cfg_view

    // pick the sample tick; the reserved code never samples
    function automatic logic tick_sel(input logic [2:0] s, input logic [6:0] t);
        logic r;
        r = 1'b0;
        if (s != `PPCF_CSEL_RESERVED) begin
            r = t[s];
        end
        return r;
    endfunction : tick_sel

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [31:0] cfg_ff [NUM_PINS];
    logic [31:0] rd_data_ff;
    logic [1:0] wr_hit;
    logic [1:0] rd_hit;

    assign wr_hit = addr_dec(addr_i);
    assign rd_hit = addr_dec(addr_i);

    // config writes; only writable bits are stored
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                cfg_ff[i] <= `PPCF_CFG_RESET;
            end
        end else if (wr_i && wr_hit[1]) begin
            cfg_ff[wr_hit[0]] <= wr_data_i & `PPCF_CFG_WMASK;
        end
    end

    // read data one cycle after the strobe, zero when unmapped or idle
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_ff <= 32'h00000000;
        end else if (rd_i && rd_hit[1]) begin
            rd_data_ff <= cfg_view(cfg_ff[rd_hit[0]]);
        end else begin
            rd_data_ff <= 32'h00000000;
        end
    end

    assign rd_data_o = rd_data_ff;

    // ------------------------------------------------------------
    // per-pin logic
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] samp_tick;
    logic [NUM_PINS-1:0] filt_level;
    logic [NUM_PINS-1:0] level_ff;
    logic [NUM_PINS-1:0] drive_ff;
    logic [NUM_PINS-1:0] oe_ff;
    logic [2*NUM_PINS-1:0] pull_ff;
    logic [NUM_PINS-1:0] schmitt_ff;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gen_pin
            logic [2:0] csel;
            logic [1:0] depth;
            assign csel = cfg_ff[g][`PPCF_CSEL_MSB:`PPCF_CSEL_LSB];
            assign depth = cfg_ff[g][`PPCF_DEPTH_MSB:`PPCF_DEPTH_LSB];

            // divider ticks arrive on this clock, so no synchroniser
            assign samp_tick[g] = tick_sel(csel, div_tick_i);

            ppcf_filter u_filter (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .pin_i(pin_i[g]),
                .tick_i(samp_tick[g]),
                .depth_i(depth),
                .level_o(filt_level[g])
            );

            // polarity applied after the filter so both levels filter alike
            always_ff @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    level_ff[g] <= 1'b0;
                end else begin
                    level_ff[g] <= filt_level[g] ^ cfg_ff[g][`PPCF_FLIP_BIT];
                end
            end

            // pseudo open-drain: drive low only, release for a one
            always_ff @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    drive_ff[g] <= 1'b0;
                    oe_ff[g] <= 1'b0;
                end else if (cfg_ff[g][`PPCF_POD_BIT]) begin
                    drive_ff[g] <= 1'b0;
                    oe_ff[g] <= gpio_dir_i[g] & ~gpio_out_i[g];
                end else begin
                    drive_ff[g] <= gpio_out_i[g];
                    oe_ff[g] <= gpio_dir_i[g];
                end
            end

            // pad analogue controls, registered to keep outputs glitch free
            always_ff @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    pull_ff[2*g+:2] <= ppcf_pkg::PPCF_PULL_UP;
                    schmitt_ff[g] <= 1'b0;
                end else begin
                    pull_ff[2*g+:2] <= cfg_ff[g][`PPCF_PULL_MSB:`PPCF_PULL_LSB];
                    schmitt_ff[g] <= cfg_ff[g][`PPCF_SCHMITT_BIT];
                end
            end
        end
    endgenerate

    assign pin_level_o = level_ff;
    assign pad_drive_o = drive_ff;
    assign pad_oe_o = oe_ff;
    assign pull_mode_o = pull_ff;
    assign schmitt_trigger_select_o = schmitt_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_rd_twelve;
        rd_i && addr_i == `PPCF_PIN_TWELVE_ADDR;
    endsequence

    sequence s_rd_five;
        rd_i && addr_i == `PPCF_PIN_FIVE_ADDR;
    endsequence

    sequence s_wr_twelve;
        wr_i && addr_i == `PPCF_PIN_TWELVE_ADDR;
    endsequence

    // a write followed by a read returns the written field bits
    AST_RD_TWELVE: assert property (s_wr_twelve ##1 (s_rd_twelve and !wr_i) |=> rd_data_ff == (($past(wr_data_i, 2) & 32'h0000FC78) | 32'h00000080))
        else $error("first pin readback wrong");
    AST_RD_FIVE: assert property (s_rd_five |=> rd_data_ff == ($past(cfg_ff[1]) | 32'h00000080))
        else $error("second pin readback wrong");
    AST_RD_RSV: assert property ((s_rd_twelve or s_rd_five) |=> rd_data_ff[31:16] == 16'h0000 && rd_data_ff[9:7] == 3'h1 && rd_data_ff[2:0] == 3'h0)
        else $error("reserved bits read wrong");
    AST_RD_IDLE: assert property (!rd_i |=> rd_data_ff == 32'h00000000)
        else $error("read data outside read cycle");
    AST_PULL: assert property (1'b1 |=> pull_ff[1:0] == $past(cfg_ff[0][4:3]))
        else $error("pull mode not following register");
    AST_FLIP: assert property (1'b1 |=> level_ff[0] == ($past(filt_level[0]) ^ $past(cfg_ff[0][6])))
        else $error("polarity flip wrong");
    AST_POD: assert property ((cfg_ff[0][10] && gpio_out_i[0]) |=> !oe_ff[0] && !drive_ff[0])
        else $error("pseudo open-drain drove a one");
    AST_CSEL: assert property ((cfg_ff[0][15:13] == 3'h7) |-> !samp_tick[0])
        else $error("reserved clock code sampled");
    AST_CSEL_PICK: assert property ((cfg_ff[1][15:13] != 3'h7) |-> samp_tick[1] == div_tick_i[cfg_ff[1][15:13]])
        else $error("wrong divider tick chosen");

    // ------------------------------------------------------------
    // per-pin checks
    // ------------------------------------------------------------
    // the same checks run on every pin, so a fault that only hits the
    // second register cannot hide behind the first one
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gen_chk
            // only two addresses decode; further pins would alias the second
            localparam logic [31:0] PIN_ADDR = (g == 0) ? `PPCF_PIN_TWELVE_ADDR :
                `PPCF_PIN_FIVE_ADDR;

            sequence s_wr_pin;
                wr_i && addr_i == PIN_ADDR;
            endsequence

            sequence s_rd_pin;
                rd_i && addr_i == PIN_ADDR;
            endsequence

            // write, then a read of the same pin on the very next cycle
            sequence s_wr_then_rd;
                s_wr_pin ##1 s_rd_pin;
            endsequence

            // read, then a cycle without a read strobe
            sequence s_rd_then_idle;
                s_rd_pin ##1 !rd_i;
            endsequence

            // a write stores exactly the writable bits
            AST_WR_LAND: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                s_wr_pin |=> cfg_ff[g] == ($past(wr_data_i) & `PPCF_CFG_WMASK))
                else $error("pin write did not land");

            // no write to this pin, no change to its register
            AST_WR_KEEP: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                !(wr_i && addr_i == PIN_ADDR) |=> $stable(cfg_ff[g]))
                else $error("pin register changed without a write");

            // back-to-back write and read must not see stale data
            AST_WR_RD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                s_wr_then_rd |=> rd_data_ff ==
                (($past(wr_data_i, 2) & `PPCF_CFG_WMASK) | `PPCF_CFG_FIXED))
                else $error("write then read gave stale data");

            // read data show the stored bits and the fixed reserved ones
            AST_RD_PIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                s_rd_pin |=> rd_data_ff ==
                (($past(cfg_ff[g]) & `PPCF_CFG_WMASK) | `PPCF_CFG_FIXED))
                else $error("pin readback wrong");

            // read data vanish in the cycle after they stood
            AST_RD_ONCE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                s_rd_then_idle |=> rd_data_ff == 32'h00000000)
                else $error("read data stood too long");

            // a write cycle never leaves read data behind
            AST_WR_NO_RD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                s_wr_pin |=> rd_data_ff == 32'h00000000)
                else $error("read data after a write");

            // pull and hysteresis outputs trail the register by one cycle
            AST_PULL_PIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                1'b1 |=> pull_ff[2*g+:2] == $past(cfg_ff[g][`PPCF_PULL_MSB:`PPCF_PULL_LSB]))
                else $error("pull output not following register");

            AST_SCHMITT_PIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                1'b1 |=> schmitt_ff[g] == $past(cfg_ff[g][`PPCF_SCHMITT_BIT]))
                else $error("hysteresis output not following register");

            // polarity acts on the filtered level
            AST_FLIP_PIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                1'b1 |=> level_ff[g] == $past(filt_level[g] ^ cfg_ff[g][`PPCF_FLIP_BIT]))
                else $error("pin polarity wrong");

            // pseudo open-drain never drives a high level
            AST_POD_LOW: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                cfg_ff[g][`PPCF_POD_BIT] |=> !drive_ff[g])
                else $error("pseudo open-drain drove high");

            AST_POD_OE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                cfg_ff[g][`PPCF_POD_BIT] |=> oe_ff[g] == $past(gpio_dir_i[g] & ~gpio_out_i[g]))
                else $error("pseudo open-drain enable wrong");

            // with the mode off the pad follows the gpio side
            AST_PLAIN_PAD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                !cfg_ff[g][`PPCF_POD_BIT] |=>
                drive_ff[g] == $past(gpio_out_i[g]) && oe_ff[g] == $past(gpio_dir_i[g]))
                else $error("plain pad drive wrong");

            // the sample tick comes from the selected divider line only
            AST_TICK_PIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                cfg_ff[g][`PPCF_CSEL_MSB:`PPCF_CSEL_LSB] != `PPCF_CSEL_RESERVED |->
                samp_tick[g] == div_tick_i[cfg_ff[g][`PPCF_CSEL_MSB:`PPCF_CSEL_LSB]])
                else $error("pin sample tick wrong");
        end
    endgenerate
endmodule : ppcf_top

// ### hw/ppcf_map.svh
// register offsets, field positions, reset values and codes of the pad config block
`ifndef PPCF_MAP_SVH
`define PPCF_MAP_SVH
// ------------------------------------------------------------
// byte addresses
// ------------------------------------------------------------
`define PPCF_PIN_TWELVE_ADDR 32'h40044008
`define PPCF_PIN_FIVE_ADDR 32'h4004400C
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PPCF_PULL_LSB 3
`define PPCF_PULL_MSB 4
`define PPCF_SCHMITT_BIT 5
`define PPCF_FLIP_BIT 6
`define PPCF_RSV_LSB 7
`define PPCF_RSV_MSB 9
`define PPCF_POD_BIT 10
`define PPCF_DEPTH_LSB 11
`define PPCF_DEPTH_MSB 12
`define PPCF_CSEL_LSB 13
`define PPCF_CSEL_MSB 15
// ------------------------------------------------------------
// reset value, writable mask, fixed bits, codes
// ------------------------------------------------------------
`define PPCF_CFG_RESET 32'h00000090
`define PPCF_CFG_WMASK 32'h0000FC78
`define PPCF_CFG_FIXED 32'h00000080
`define PPCF_DEPTH_BYPASS 2'h0
`define PPCF_CSEL_RESERVED 3'h7
`define PPCF_NUM_DIV 7
`endif

// ### hw/ppcf_pkg.sv
// shared types of the pad config block
package ppcf_pkg;
    // pull resistor modes
    typedef enum logic [1:0] {
        PPCF_PULL_NONE = 2'b00,
        PPCF_PULL_DOWN = 2'b01,
        PPCF_PULL_UP = 2'b10,
        PPCF_PULL_REPEAT = 2'b11
    } ppcf_pull_t;
    // glitch filter depths
    typedef enum logic [1:0] {
        PPCF_DEPTH_OFF = 2'b00,
        PPCF_DEPTH_ONE = 2'b01,
        PPCF_DEPTH_TWO = 2'b10,
        PPCF_DEPTH_THREE = 2'b11
    } ppcf_depth_t;
endpackage : ppcf_pkg

// ### hw/ppcf_filter.sv
// pin synchroniser and sampled glitch filter for one pad
`timescale 1ns/1ns
`include "ppcf_map.svh"
module ppcf_filter (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    input wire logic tick_i,
    input wire logic [1:0] depth_i,
    output logic level_o
);
    logic sync1_ff, sync2_ff, sync3_ff;
    logic stable_ff;
    logic level_ff;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;

    // three-stage synchroniser; only the agreeing pair is looked at
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            stable_ff <= 1'b0;
        end else if (sync2_ff == sync3_ff) begin
            stable_ff <= sync3_ff;
        end
    end

    assign nxt_cnt = cnt_ff + 2'h1;

    // n consecutive new-level samples move the output
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            level_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else if (depth_i == `PPCF_DEPTH_BYPASS) begin
            level_ff <= stable_ff;
            cnt_ff <= 2'h0;
        end else if (tick_i) begin
            if (stable_ff == level_ff) begin
                cnt_ff <= 2'h0;
            // at-or-above, so a depth lowered mid-count cannot wrap the counter
            end else if (nxt_cnt >= depth_i) begin
                level_ff <= stable_ff;
                cnt_ff <= 2'h0;
            end else begin
                cnt_ff <= nxt_cnt;
            end
        end
    end

    assign level_o = level_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_new_sample;
        tick_i && (stable_ff != level_ff);
    endsequence
    AST_FILT_BYPASS: assert property ((depth_i == 2'h0) |=> level_ff == $past(stable_ff))
        else $error("bypass did not pass level");
    AST_FILT_HOLD: assert property ((!tick_i && depth_i != 2'h0) |=> $stable(level_ff))
        else $error("filter moved without a sample");
    AST_FILT_ONE: assert property ((depth_i == 2'h1) ##0 s_new_sample |=> level_ff != $past(level_ff))
        else $error("depth one did not follow sample");
    AST_FILT_TWO: assert property ((depth_i == 2'h2 && cnt_ff == 2'h0) ##0 s_new_sample |=> $stable(level_ff) && cnt_ff == 2'h1)
        else $error("depth two moved on first sample");
    AST_FILT_THREE: assert property ((depth_i == 2'h3 && cnt_ff == 2'h1) ##0 s_new_sample |=> $stable(level_ff) && cnt_ff == 2'h2)
        else $error("depth three moved on second sample");
endmodule : ppcf_filter

// ### verification/pin_pad_config_filter_bench.sv
// self-checking bench of the pad configuration registers and glitch filters
`timescale 1ns/1ns
`include "ppcf_map.svh"
module pin_pad_config_filter_bench;
    // ------------------------------------------------------------
    // stimulus and observed outputs
    // ------------------------------------------------------------
    logic sys_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [31:0] addr_i = 32'h00000000;
    logic [31:0] wr_data_i = 32'h00000000;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [6:0] div_tick_i = 7'h00;
    logic [1:0] pin_i = 2'h0;
    logic [1:0] gpio_out_i = 2'h0;
    logic [1:0] gpio_dir_i = 2'h0;
    logic [31:0] rd_data_o;
    logic [1:0] pin_level_o, pad_drive_o, pad_oe_o, schmitt_trigger_select_o;
    logic [3:0] pull_mode_o;
    int error_cnt = 0;
    int checked = 0;

    ppcf_top #(.NUM_PINS(2)) DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .div_tick_i(div_tick_i), .pin_i(pin_i), .gpio_out_i(gpio_out_i),
        .gpio_dir_i(gpio_dir_i), .pin_level_o(pin_level_o), .pad_drive_o(pad_drive_o),
        .pad_oe_o(pad_oe_o), .pull_mode_o(pull_mode_o),
        .schmitt_trigger_select_o(schmitt_trigger_select_o));

    // 25 MHz system clock
    always #20 sys_clk_i = ~sys_clk_i;

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // waits whole cycles, then steps off the edge so outputs are settled
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : wait_cyc

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'h1;
        @(posedge sys_clk_i);
        wr_i <= 1'h0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge sys_clk_i);
        rd_i <= 1'h0;
        #1;
        d = rd_data_o;
    endtask : rd_reg

    // write, then read the same address on the very next cycle
    task automatic wr_rd_back(input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'h1;
        @(posedge sys_clk_i);
        wr_i <= 1'h0;
        rd_i <= 1'h1;
        @(posedge sys_clk_i);
        rd_i <= 1'h0;
        #1;
        q = rd_data_o;
    endtask : wr_rd_back

    // one-cycle pulses on one divider line, with a gap between them
    task automatic tick(input int k, input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            div_tick_i <= 7'h01 << k;
            @(posedge sys_clk_i);
            div_tick_i <= 7'h00;
        end
    endtask : tick

    function automatic logic [31:0] cfg(input logic [1:0] pull, input logic flip,
        input logic pod, input logic [1:0] depth, input logic [2:0] csel);
        cfg = {16'h0000, csel, depth, pod, 3'h0, flip, 1'h0, pull, 3'h0};
    endfunction : cfg

    task automatic wr_both(input logic [31:0] d);
        wr_reg(`PPCF_PIN_TWELVE_ADDR, d);
        wr_reg(`PPCF_PIN_FIVE_ADDR, d);
    endtask : wr_both

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        logic [31:0] d;
        rd_reg(`PPCF_PIN_TWELVE_ADDR, d);
        chk("pin twelve reset", 32'h00000090, d);
        rd_reg(`PPCF_PIN_FIVE_ADDR, d);
        chk("pin five reset", 32'h00000090, d);
        chk("pull reset", 32'h0000000A, {28'h0000000, pull_mode_o});
        chk("schmitt reset", 32'h00000000, {30'h00000000, schmitt_trigger_select_o});
        $display("test_reset done");
    endtask : test_reset

    task automatic test_regs();
        logic [31:0] d;
        // every bit set except the one that would make the reserved clock code
        wr_reg(`PPCF_PIN_TWELVE_ADDR, 32'hFFFFDFFF);
        rd_reg(`PPCF_PIN_TWELVE_ADDR, d);
        chk("wide readback", 32'h0000DCF8, d);
        rd_reg(`PPCF_PIN_FIVE_ADDR, d);
        chk("neighbour untouched", 32'h00000090, d);
        chk("schmitt out", 32'h00000001, {30'h00000000, schmitt_trigger_select_o});
        // a write next door, then a read of that unmapped address must give zero
        wr_reg(32'h40044010, 32'h0000FFFF);
        rd_reg(32'h40044010, d);
        chk("unmapped read", 32'h00000000, d);
        for (int p = 0; p < 4; p++) begin
            wr_reg(`PPCF_PIN_FIVE_ADDR, {27'h0000000, p[1:0], 3'h0});
            rd_reg(`PPCF_PIN_FIVE_ADDR, d);
            chk("pull readback", {27'h0000000, p[1:0], 3'h0} | 32'h00000080, d);
            chk("pull out", {30'h00000000, p[1:0]}, {30'h00000000, pull_mode_o[3:2]});
        end
        wr_rd_back(`PPCF_PIN_TWELVE_ADDR, 32'h0000A5A5, d);
        chk("back to back twelve", 32'h0000A4A0, d);
        wr_rd_back(`PPCF_PIN_FIVE_ADDR, 32'h00005A5A, d);
        chk("back to back five", 32'h000058D8, d);
        wr_reg(`PPCF_PIN_TWELVE_ADDR, 32'h00000000);
        rd_reg(`PPCF_PIN_TWELVE_ADDR, d);
        chk("zero readback", 32'h00000080, d);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_drive();
        logic [1:0] e_drv, e_oe;
        wr_reg(`PPCF_PIN_FIVE_ADDR, cfg(2'h2, 1'h0, 1'h0, 2'h0, 3'h0));
        for (int m = 0; m < 8; m++) begin
            wr_reg(`PPCF_PIN_TWELVE_ADDR, cfg(2'h2, 1'h0, m[2], 2'h0, 3'h0));
            @(posedge sys_clk_i);
            gpio_out_i <= {2{m[0]}};
            gpio_dir_i <= {2{m[1]}};
            wait_cyc(3);
            e_drv = {m[0], m[2] ? 1'h0 : m[0]};
            e_oe = {m[1], m[2] ? (m[1] & ~m[0]) : m[1]};
            chk("pad drive", {30'h00000000, e_drv}, {30'h00000000, pad_drive_o});
            chk("pad enable", {30'h00000000, e_oe}, {30'h00000000, pad_oe_o});
        end
        $display("test_drive done");
    endtask : test_drive

    // no ticks are given, so only a bypassed filter lets the level through
    task automatic test_bypass();
        for (int f = 0; f < 2; f++) begin
            wr_both(cfg(2'h2, f[0], 1'h0, 2'h0, 3'h0));
            for (int v = 0; v < 2; v++) begin
                @(posedge sys_clk_i);
                pin_i <= {2{v[0]}};
                wait_cyc(8);
                chk("bypass level", {30'h00000000, {2{v[0] ^ f[0]}}},
                    {30'h00000000, pin_level_o});
            end
        end
        $display("test_bypass done");
    endtask : test_bypass

    task automatic test_filter();
        int n;
        for (int c = 0; c < 7; c++) begin
            n = c % 3 + 1;
            wr_both(cfg(2'h2, 1'h0, 1'h0, n[1:0], c[2:0]));
            @(posedge sys_clk_i);
            pin_i <= 2'h0;
            wait_cyc(6);
            tick(c, 3);
            wait_cyc(3);
            chk("filter settled low", 32'h00000000, {30'h00000000, pin_level_o});
            // a short pulse, a resetting sample, then one tick short of the depth
            @(posedge sys_clk_i);
            pin_i <= 2'h3;
            wait_cyc(6);
            tick(c, n - 1);
            @(posedge sys_clk_i);
            pin_i <= 2'h0;
            wait_cyc(6);
            tick(c, 1);
            @(posedge sys_clk_i);
            pin_i <= 2'h3;
            wait_cyc(6);
            tick(c, n - 1);
            tick((c + 1) % 7, 4);
            wait_cyc(3);
            chk("filter holds", 32'h00000000, {30'h00000000, pin_level_o});
            tick(c, 1);
            wait_cyc(3);
            chk("filter passes", 32'h00000003, {30'h00000000, pin_level_o});
        end
        $display("test_filter done");
    endtask : test_filter

    // ------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'h0;
        test_reset();
        test_regs();
        test_drive();
        test_bypass();
        test_filter();
        finish_test();
    end

    // the tests need well under two thousand cycles; this is a generous margin
    initial begin
        #(40 * 20000);
        error_cnt++;
        finish_test();
    end
endmodule : pin_pad_config_filter_bench
